// *** design/ssp_pkg.sv ***
// constants and types shared by the synchronous serial port
package ssp_pkg;
    // ==========================================================
    // apb register indexes, byte address is four times the index
    localparam int PADDR_W = 18;
    localparam logic [15:0] IDX_CONTROL = 16'hFE30;
    localparam logic [15:0] IDX_SHIFT = 16'hFE31;
    localparam logic [15:0] IDX_BAUD = 16'hFE32;
    localparam logic [15:0] IDX_LENGTH = 16'hFE33;
    localparam logic [15:0] IDX_CONT_CTRL = 16'hFE37;
    localparam logic [15:0] IDX_PORT_CFG = 16'hFE38;
    localparam logic [15:0] IDX_RAM_BASE = 16'h01C0;
    localparam int RAM_DEPTH = 64;
    localparam int RAM_AW = 6;

    // ==========================================================
    // serial_control fields
    localparam int BIT_BANK = 7;
    localparam int BIT_SWAP = 6;
    localparam int BIT_RUN = 5;
    localparam int BIT_CONT = 4;
    localparam int BIT_MSB = 3;
    localparam int BIT_OVR = 2;
    localparam int BIT_END = 1;
    localparam int BIT_IE = 0;
    // continuous_transfer_control fields
    localparam int BIT_SUSPEND = 7;
    localparam int BYTE_COUNT_W = 5;
    // port configuration fields
    localparam int BIT_EXT_CLK = 0;
    localparam int BIT_TWO_WIRE = 1;

    // ==========================================================
    // reset values, counts and the interrupt vector
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [8:0] SINGLE_BITS = 9'h008;
    localparam logic [2:0] LAST_BIT_IN_BYTE = 3'h7;
    localparam logic [15:0] IRQ_VECTOR = 16'h0033;

    typedef enum logic [1:0] {ST_IDLE, ST_MOVE, ST_SHIFT, ST_HOLD} ssp_state_e;
endpackage

// *** design/ssp_baud_gen.sv ***
// reload divider producing half-period ticks for the internal shift clock
`timescale 1ns/100ps
`default_nettype none
module ssp_baud_gen (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic en,
    input wire logic [7:0] div,
    output logic tick
);
    // ==========================================================
    // reload counter
    logic [7:0] cnt_r;
    logic [7:0] cnt_nxt;

    // reloads on every expiry, and from the divider while stopped
    assign cnt_nxt = (!en || cnt_r == 8'h00) ? div : cnt_r - 8'h01; // R24
    assign tick = en && (cnt_r == 8'h00); // R02

    always_ff @(posedge clk_sys)
    begin
        if (reset)
            cnt_r <= 8'h00;
        else
            cnt_r <= cnt_nxt;
    end

    // ==========================================================
    // checks
    reload_after_tick_a: assert property (@(posedge clk_sys) disable iff (reset)
        (en && tick) |=> (cnt_r == $past(div))) // R24
        else $error("divider not reloaded after expiry");
endmodule
`default_nettype wire

// *** design/ssp_serial_port.sv ***
// synchronous serial port with single-byte and continuous ram-backed transfers
//
// Overview of operation
// R01: single 8-bit mode and 1..256-bit continuous mode
// R02: internal clock period (n+1)*2/3 tcyc, n nonzero; the divider gives a period of 2*(n+1) clk_sys cycles, and n of 0 is accepted
// R03: two or three wire, internal or external clock
// R04: continuous mode suspends only at byte boundaries
// R05: continuous mode moves bytes between ram and shifter
// R06: interrupt when enable and end flag set
// R07: bank bit selects upper or lower ram window
// R08: swap bit exchanges, otherwise copies ram to shifter
// R09: software sets run, device clears at last rise
// R10: mode bit selects continuous, cleared at end
// R11: order bit selects msb or lsb first
// R12: overrun on clock fall while not running
// R13: overrun on clock fall during ram move
// R14: end flag set at last rise, software clears
// R15: shifter sends and receives on same clock
// R16: software reads and writes shifter directly
// R17: byte count readable during continuous transfer
// R18: length register sets continuous transfer length
// R19: continuous bits equal length value plus one
// R20: suspend bit halts after byte, clear resumes
// R21: start at bank base, advance every byte
// R22: final partial byte stays in shifter
// R23: drive on falling edge, sample on rising
// R24: divider reloads on expiry, runs only internally
//
// Local design decision: the APB register port.
`timescale 1ns/100ps
`default_nettype none
module ssp_serial_port (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ssp_pkg::PADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic sck_i,
    output logic sck_o,
    output logic sck_oe,
    output logic sdo,
    input wire logic sdi,
    input wire logic sdio_i,
    output logic sdio_o,
    output logic sdio_oe,
    output logic irq
);
    // ==========================================================
    // declarations
    ssp_pkg::ssp_state_e state_r;
    ssp_pkg::ssp_state_e state_nxt;
    logic [7:0] ctrl_r;
    logic [7:0] ctrl_nxt;
    logic [7:0] shift_r;
    logic [7:0] baud_r;
    logic [7:0] length_r;
    logic [2:0] cont_user_r;
    logic [1:0] cfg_r;
    logic [ssp_pkg::BYTE_COUNT_W-1:0] byte_count_r;
    logic [8:0] bits_left_r;
    logic [2:0] bit_in_byte_r;
    logic [7:0] ram_r [0:ssp_pkg::RAM_DEPTH-1];
    logic sck_int_r;
    logic sck_s1_r;
    logic sck_s2_r;
    logic sck_s3_r;
    logic sdi_s1_r;
    logic sdi_s2_r;
    logic sdio_s1_r;
    logic sdio_s2_r;
    logic [31:0] prdata_r;
    logic pready_r;
    logic pslverr_r;
    logic sdo_r;
    logic sdio_oe_r;
    logic irq_r;
    logic baud_tick;

    // ==========================================================
    // helpers
    function automatic logic idx_is(input logic [15:0] idx, input logic [15:0] want);
        idx_is = (idx == want);
    endfunction

    function automatic logic [7:0] shift_in(input logic [7:0] cur, input logic din,
        input logic msb_first);
        shift_in = msb_first ? {cur[6:0], din} : {din, cur[7:1]};
    endfunction

    // ==========================================================
    // apb decode
    wire [15:0] idx = paddr[ssp_pkg::PADDR_W-1:2];
    wire acc = psel && penable && !pready_r;
    wire done = psel && penable && pready_r;
    wire wr_en = done && pwrite;
    wire [7:0] wbyte = pwdata[7:0];
    wire hit_ctrl = idx_is(idx, ssp_pkg::IDX_CONTROL);
    wire hit_shift = idx_is(idx, ssp_pkg::IDX_SHIFT);
    wire hit_baud = idx_is(idx, ssp_pkg::IDX_BAUD);
    wire hit_len = idx_is(idx, ssp_pkg::IDX_LENGTH);
    wire hit_cont = idx_is(idx, ssp_pkg::IDX_CONT_CTRL);
    wire hit_cfg = idx_is(idx, ssp_pkg::IDX_PORT_CFG);
    wire hit_ram = (idx[15:ssp_pkg::RAM_AW] == ssp_pkg::IDX_RAM_BASE[15:ssp_pkg::RAM_AW]);
    wire [ssp_pkg::RAM_AW-1:0] sw_ram_idx = idx[ssp_pkg::RAM_AW-1:0];
    wire hit_any = hit_ctrl | hit_shift | hit_baud | hit_len | hit_cont | hit_cfg | hit_ram;
    wire [7:0] cont_rd = {cont_user_r, byte_count_r}; // R17
    wire [7:0] rd_byte = hit_ctrl ? ctrl_r :
                         hit_shift ? shift_r : // R16
                         hit_baud ? baud_r :
                         hit_len ? length_r :
                         hit_cont ? cont_rd :
                         hit_cfg ? {6'h00, cfg_r} :
                         hit_ram ? ram_r[sw_ram_idx] : 8'h00;

    // ==========================================================
    // clock and data pin synchronisers
    wire ext_sel = cfg_r[ssp_pkg::BIT_EXT_CLK]; // R03
    wire two_wire = cfg_r[ssp_pkg::BIT_TWO_WIRE]; // R03
    wire ext_fall = !sck_s2_r && sck_s3_r;
    wire ext_rise = sck_s2_r && !sck_s3_r;
    wire int_fall = baud_tick && sck_int_r;
    wire int_rise = baud_tick && !sck_int_r;
    wire fall_ev = ext_sel ? ext_fall : int_fall;
    wire rise_ev = ext_sel ? ext_rise : int_rise;
    wire din = two_wire ? sdio_s2_r : sdi_s2_r;

    // ==========================================================
    // sequencing terms
    wire idle = (state_r == ssp_pkg::ST_IDLE);
    wire shifting = (state_r == ssp_pkg::ST_SHIFT);
    wire moving = (state_r == ssp_pkg::ST_MOVE);
    wire cont_mode = ctrl_r[ssp_pkg::BIT_CONT];
    wire msb_first = ctrl_r[ssp_pkg::BIT_MSB];
    wire swap_en = ctrl_r[ssp_pkg::BIT_SWAP];
    wire suspend = cont_user_r[2];
    wire wr_ctrl = wr_en && hit_ctrl;
    wire start = wr_ctrl && idle && wbyte[ssp_pkg::BIT_RUN]; // R09
    wire start_cont = start && wbyte[ssp_pkg::BIT_CONT]; // R10
    wire last_bit = (bits_left_r == 9'h001);
    wire byte_end = (bit_in_byte_r == ssp_pkg::LAST_BIT_IN_BYTE);
    wire shift_rise = shifting && rise_ev;
    wire last_rise = shift_rise && last_bit;
    wire byte_done = shift_rise && byte_end && !last_bit;
    // only an external clock can arrive unasked; ours is held high when not shifting
    wire ovr_ev = ext_sel && ext_fall && (idle || moving); // R12 R13
    wire [ssp_pkg::RAM_AW-1:0] dev_ram_idx = {ctrl_r[ssp_pkg::BIT_BANK], byte_count_r}; // R07 R21
    wire [7:0] ram_rd = ram_r[dev_ram_idx];
    wire tx_bit = msb_first ? shift_r[7] : shift_r[0]; // R11
    wire [8:0] cont_bits = {1'b0, length_r} + 9'h001; // R18 R19

    // ==========================================================
    // baud generator
    ssp_baud_gen u_baud (
        .clk_sys(clk_sys),
        .reset(reset),
        .en(shifting && !ext_sel), // R24
        .div(baud_r), // R02
        .tick(baud_tick)
    );

    // ==========================================================
    // control register next value
    always_comb
    begin
        ctrl_nxt = ctrl_r;
        if (wr_ctrl)
        begin
            ctrl_nxt[ssp_pkg::BIT_BANK] = wbyte[ssp_pkg::BIT_BANK];
            ctrl_nxt[ssp_pkg::BIT_SWAP] = wbyte[ssp_pkg::BIT_SWAP];
            ctrl_nxt[ssp_pkg::BIT_MSB] = wbyte[ssp_pkg::BIT_MSB];
            ctrl_nxt[ssp_pkg::BIT_IE] = wbyte[ssp_pkg::BIT_IE];
            // flags can only be cleared by software
            ctrl_nxt[ssp_pkg::BIT_OVR] = ctrl_r[ssp_pkg::BIT_OVR] && wbyte[ssp_pkg::BIT_OVR];
            ctrl_nxt[ssp_pkg::BIT_END] = ctrl_r[ssp_pkg::BIT_END] && wbyte[ssp_pkg::BIT_END];
            if (idle)
            begin
                ctrl_nxt[ssp_pkg::BIT_RUN] = wbyte[ssp_pkg::BIT_RUN]; // R09
                ctrl_nxt[ssp_pkg::BIT_CONT] = wbyte[ssp_pkg::BIT_CONT]; // R10
            end
        end
        // hardware events override a simultaneous software clear
        if (last_rise)
        begin
            ctrl_nxt[ssp_pkg::BIT_RUN] = 1'b0; // R09
            ctrl_nxt[ssp_pkg::BIT_CONT] = 1'b0; // R10
            ctrl_nxt[ssp_pkg::BIT_END] = 1'b1; // R14
        end
        if (ovr_ev)
            ctrl_nxt[ssp_pkg::BIT_OVR] = 1'b1; // R12 R13
    end

    // ==========================================================
    // state machine
    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            ssp_pkg::ST_IDLE:
                if (start)
                    state_nxt = start_cont ? ssp_pkg::ST_MOVE : ssp_pkg::ST_SHIFT; // R01 R05
            ssp_pkg::ST_MOVE:
                state_nxt = ssp_pkg::ST_SHIFT;
            ssp_pkg::ST_SHIFT:
                if (last_rise)
                    state_nxt = ssp_pkg::ST_IDLE;
                else if (byte_done && cont_mode)
                    state_nxt = suspend ? ssp_pkg::ST_HOLD : ssp_pkg::ST_MOVE; // R04 R20
            ssp_pkg::ST_HOLD:
                if (!suspend)
                    state_nxt = ssp_pkg::ST_MOVE; // R20
            default:
                state_nxt = ssp_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys)
    begin
        if (reset)
            state_r <= ssp_pkg::ST_IDLE;
        else
            state_r <= state_nxt;
    end

    always_ff @(posedge clk_sys)
    begin
        if (reset)
            ctrl_r <= ssp_pkg::RESET_BYTE;
        else
            ctrl_r <= ctrl_nxt;
    end

    // ==========================================================
    // software registers
    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            baud_r <= ssp_pkg::RESET_BYTE;
            length_r <= ssp_pkg::RESET_BYTE;
            cont_user_r <= 3'h0;
            cfg_r <= 2'h0;
        end
        else if (wr_en)
        begin
            if (hit_baud)
                baud_r <= wbyte;
            if (hit_len)
                length_r <= wbyte; // R18
            if (hit_cont)
                cont_user_r <= wbyte[7:5]; // R20
            if (hit_cfg && idle)
                cfg_r <= wbyte[1:0];
        end
    end

    // ==========================================================
    // bit and byte counters
    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            bits_left_r <= 9'h000;
            bit_in_byte_r <= 3'h0;
            byte_count_r <= '0;
        end
        else if (start)
        begin
            bits_left_r <= start_cont ? cont_bits : ssp_pkg::SINGLE_BITS; // R01 R19
            bit_in_byte_r <= 3'h0;
            byte_count_r <= '0; // R21
        end
        else if (shift_rise)
        begin
            bits_left_r <= bits_left_r - 9'h001;
            bit_in_byte_r <= bit_in_byte_r + 3'h1;
            if (byte_done && cont_mode)
                byte_count_r <= byte_count_r + 5'h01; // R17 R21
        end
    end

    // ==========================================================
    // shift register and data ram
    always_ff @(posedge clk_sys)
    begin
        if (reset)
            shift_r <= ssp_pkg::RESET_BYTE;
        else if (moving)
            shift_r <= ram_rd; // R05 R08
        else if (shift_rise)
            shift_r <= shift_in(shift_r, din, msb_first); // R15 R23
        else if (wr_en && hit_shift && idle)
            shift_r <= wbyte; // R16
    end

    // the final bits never reach a move, so they stay in the shifter
    always_ff @(posedge clk_sys)
    begin
        if (moving && swap_en)
            ram_r[dev_ram_idx] <= shift_r; // R08 R22
        else if (wr_en && hit_ram && !moving)
            ram_r[sw_ram_idx] <= wbyte;
    end

    // ==========================================================
    // serial pins
    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            sck_int_r <= 1'b1;
            sdo_r <= 1'b1;
            sdio_oe_r <= 1'b0;
        end
        else
        begin
            if (shifting && !ext_sel && baud_tick)
                sck_int_r <= !sck_int_r;
            else if (!shifting)
                sck_int_r <= 1'b1;
            if (shifting && fall_ev)
            begin
                sdo_r <= tx_bit; // R23 R11
                sdio_oe_r <= two_wire && !tx_bit; // R03
            end
            else if (idle)
            begin
                sdo_r <= 1'b1;
                sdio_oe_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            sck_s1_r <= 1'b1;
            sck_s2_r <= 1'b1;
            sck_s3_r <= 1'b1;
            sdi_s1_r <= 1'b0;
            sdi_s2_r <= 1'b0;
            sdio_s1_r <= 1'b0;
            sdio_s2_r <= 1'b0;
        end
        else
        begin
            sck_s1_r <= sck_i;
            sck_s2_r <= sck_s1_r;
            sck_s3_r <= sck_s2_r;
            sdi_s1_r <= sdi;
            sdi_s2_r <= sdi_s1_r;
            sdio_s1_r <= sdio_i;
            sdio_s2_r <= sdio_s1_r;
        end
    end

    // ==========================================================
    // bus answer and interrupt
    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h0000_0000;
            irq_r <= 1'b0;
        end
        else
        begin
            pready_r <= acc;
            pslverr_r <= acc && !hit_any;
            if (acc && !pwrite)
                prdata_r <= {24'h000000, rd_byte};
            irq_r <= ctrl_r[ssp_pkg::BIT_IE] && ctrl_r[ssp_pkg::BIT_END]; // R06
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign sck_o = sck_int_r;
    assign sck_oe = !ext_sel;
    assign sdo = sdo_r;
    assign sdio_o = 1'b0 & sdo_r;
    assign sdio_oe = sdio_oe_r;
    assign irq = irq_r;

    // ==========================================================
    // checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    sequence last_edge_s;
        shifting && rise_ev && last_bit;
    endsequence

    sequence byte_pause_s;
        shifting && rise_ev && byte_end && !last_bit && cont_mode && suspend;
    endsequence

    run_clear_a: assert property (last_edge_s |=> !ctrl_r[ssp_pkg::BIT_RUN] && idle) // R09
        else $error("run flag not cleared at last clock");
    mode_clear_a: assert property (last_edge_s |=> !ctrl_r[ssp_pkg::BIT_CONT]) // R10
        else $error("mode bit not cleared at last clock");
    end_flag_a: assert property (last_edge_s |=> ctrl_r[ssp_pkg::BIT_END] [*2]) // R14
        else $error("end flag not set or not held");
    irq_follow_a: assert property (irq == $past(ctrl_r[ssp_pkg::BIT_IE] && ctrl_r[ssp_pkg::BIT_END])) // R06
        else $error("interrupt does not follow enable and end flag");
    overrun_idle_a: assert property (ext_sel && ext_fall && idle |=> ctrl_r[ssp_pkg::BIT_OVR]) // R12
        else $error("overrun not flagged while idle");
    overrun_move_a: assert property (ext_sel && ext_fall && moving |=> ctrl_r[ssp_pkg::BIT_OVR]) // R13
        else $error("overrun not flagged during move");
    swap_load_a: assert property (moving |=> shift_r == $past(ram_rd)) // R08
        else $error("shifter not loaded from ram");
    suspend_hold_a: assert property (byte_pause_s |=> (state_r == ssp_pkg::ST_HOLD) [*2]) // R20
        else $error("no halt at byte boundary");
    tx_order_a: assert property (shifting && fall_ev |=> sdo_r == $past(tx_bit)) // R11
        else $error("wrong bit driven on falling edge");
endmodule
`default_nettype wire

// *** test/ssp_peer.sv ***
// far-side serial peer: external clock source, data source and sink
`timescale 1ns/100ps
`default_nettype none
module ssp_peer (
    input wire logic clk_sys,
    input wire logic clr,
    input wire logic ext_go,
    input wire logic [8:0] ext_n,
    input wire logic [7:0] ext_half,
    input wire logic [31:0] tx_pat,
    input wire logic sck_o,
    input wire logic sck_oe,
    input wire logic sdo,
    input wire logic sdio_oe,
    output logic sck_i,
    output logic sdi,
    output logic sdio_i,
    output logic [31:0] rx_pat
);
    logic ext_sck_r, sck_d_r;
    logic [4:0] idx_r;
    logic [8:0] left_r;
    logic [7:0] cnt_r;
    // ==========================================================
    // wire levels
    assign sck_i = sck_oe ? sck_o : ext_sck_r;
    assign sdi = tx_pat[idx_r];
    // open drain with pull-up: low if either side pulls
    assign sdio_i = ~sdio_oe & tx_pat[idx_r];
    // ==========================================================
    // clock source, stands high between bursts
    always_ff @(posedge clk_sys)
    begin
        if (clr || ext_go)
        begin
            ext_sck_r <= 1'b1;
            left_r <= clr ? 9'h000 : ext_n;
            cnt_r <= 8'h00;
        end
        else if (left_r != 9'h000)
        begin
            cnt_r <= (cnt_r == ext_half) ? 8'h00 : cnt_r + 8'h01;
            if (cnt_r == ext_half)
            begin
                ext_sck_r <= ~ext_sck_r;
                if (!ext_sck_r)
                    left_r <= left_r - 9'h001;
            end
        end
    end
    // ==========================================================
    // data: change after a fall, capture at a rise
    always_ff @(posedge clk_sys)
    begin
        sck_d_r <= sck_i;
        if (clr)
        begin
            idx_r <= 5'h1F;
            rx_pat <= 32'h0;
        end
        else if (sck_d_r && !sck_i)
            idx_r <= idx_r + 5'h01;
        else if (!sck_d_r && sck_i)
            rx_pat <= {rx_pat[30:0], sdo};
    end
endmodule
`default_nettype wire

// *** test/sync_serial_continuous_port_test.sv ***
// self-checking bench for the synchronous serial port
`timescale 1ns/100ps
`default_nettype none
module sync_serial_continuous_port_test;
    logic clk_sys = 1'b0, reset = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [ssp_pkg::PADDR_W-1:0] paddr = '0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rx, pat = 32'h0;
    logic pready, pslverr, sck_i, sck_o, sck_oe, sdo, sdi, sdio_i, sdio_o, sdio_oe, irq;
    logic clr = 1'b1, ext_go = 1'b0;
    logic [8:0] ext_n = 9'h000;
    int n_mismatch = 0, n_tests = 0, nlow = 0;
    always #50 clk_sys = ~clk_sys;
    always @(posedge clk_sys)
        if (sck_o === 1'b0)
            nlow++;
    ssp_serial_port ssp_serial_port_inst (.clk_sys(clk_sys), .reset(reset), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .sck_i(sck_i), .sck_o(sck_o), .sck_oe(sck_oe),
        .sdo(sdo), .sdi(sdi), .sdio_i(sdio_i), .sdio_o(sdio_o), .sdio_oe(sdio_oe), .irq(irq));
    ssp_peer ssp_peer_inst (.clk_sys(clk_sys), .clr(clr), .ext_go(ext_go), .ext_n(ext_n),
        .ext_half(8'h05), .tx_pat(pat), .sck_o(sck_o), .sck_oe(sck_oe), .sdo(sdo),
        .sdio_oe(sdio_oe), .sck_i(sck_i), .sdi(sdi), .sdio_i(sdio_i), .rx_pat(rx));
    // ==========================================================
    // checking and bus tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [15:0] idx, input logic [7:0] wd,
            output logic [31:0] rd, output logic err);
        int n = 0;
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {idx, 2'b00};
        pwdata <= {24'h000000, wd};
        @(posedge clk_sys);
        penable <= 1'b1;
        do
        begin
            @(posedge clk_sys);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n == 20)
            chk({31'h0, pready}, 32'h1);
    endtask
    task automatic wr(input logic [15:0] idx, input logic [7:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, idx, d, r, e);
    endtask
    task automatic rg(input logic [15:0] idx, output logic [31:0] r);
        logic e;
        apb(1'b0, idx, 8'h00, r, e);
    endtask
    task automatic rc(input logic [15:0] idx, input logic [7:0] exp);
        logic [31:0] r;
        rg(idx, r);
        chk(r, {24'h000000, exp});
    endtask
    // ==========================================================
    // expectations
    function automatic logic [7:0] sh_in(input logic [7:0] old, input logic [31:0] b,
            input int n, input logic msb);
        logic [7:0] v = old;
        for (int k = 0; k < n; k++)
            v = msb ? {v[6:0], b[k]} : {b[k], v[7:1]};
        return v;
    endfunction
    function automatic logic [31:0] tx_stream(input logic [31:0] by, input int n,
            input logic msb);
        logic [31:0] e = 32'h0;
        for (int i = 0; i < n; i++)
            e = {e[30:0], by[8 * (i / 8) + (msb ? 7 - i % 8 : i % 8)]};
        return e;
    endfunction
    // ==========================================================
    // scenario helpers
    task automatic setup(input logic ext, input logic [7:0] dv);
        wr(ssp_pkg::IDX_PORT_CFG, {7'h00, ext});
        wr(ssp_pkg::IDX_BAUD, dv);
        wr(ssp_pkg::IDX_CONTROL, 8'h00);
        pat <= $urandom;
        clr <= 1'b1;
        @(posedge clk_sys);
        clr <= 1'b0;
    endtask
    task automatic kick(input logic [8:0] n);
        ext_n <= n;
        ext_go <= 1'b1;
        @(posedge clk_sys);
        ext_go <= 1'b0;
    endtask
    task automatic wait_end();
        logic [31:0] r;
        int n = 0;
        do
        begin
            rg(ssp_pkg::IDX_CONTROL, r);
            n++;
        end
        while (r[ssp_pkg::BIT_RUN] !== 1'b0 && n < 500);
    endtask
    task automatic single(input logic msb, input logic ext);
        logic [7:0] d, dv;
        int n0;
        d = $urandom;
        dv = 8'h04 + 8'($urandom % 4);
        setup(ext, dv);
        wr(ssp_pkg::IDX_SHIFT, d);
        n0 = nlow;
        wr(ssp_pkg::IDX_CONTROL, {4'h2, msb, 3'b001});
        if (ext)
            kick(9'h008);
        wait_end();
        chk({31'h0, irq}, 32'h1);
        rc(ssp_pkg::IDX_CONTROL, {4'h0, msb, 3'b011});
        rc(ssp_pkg::IDX_SHIFT, sh_in(d, pat, 8, msb));
        chk(rx, tx_stream({24'h0, d}, 8, msb));
        if (!ext)
            chk(32'(nlow - n0), 32'(8 * (dv + 1)));
        wr(ssp_pkg::IDX_CONTROL, 8'h01);
        repeat (2) @(posedge clk_sys);
        chk({31'h0, irq}, 32'h0);
        $display("single %0d %0d done", msb, ext);
    endtask
    task automatic cont(input logic sw);
        logic [31:0] by, r;
        logic [7:0] d, dv, e;
        logic bank, msb;
        int nbits, nb, n0, k;
        by = $urandom;
        d = $urandom;
        dv = 8'h04 + 8'($urandom % 4);
        bank = 1'($urandom);
        msb = 1'($urandom);
        nbits = 17 + $urandom % 16;
        nb = (nbits + 7) / 8;
        setup(1'b0, dv);
        wr(ssp_pkg::IDX_LENGTH, 8'(nbits - 1));
        for (k = 0; k < 4; k++)
            wr(ssp_pkg::IDX_RAM_BASE + {10'h000, bank, 5'(k)}, by[8 * k +: 8]);
        wr(ssp_pkg::IDX_SHIFT, d);
        wr(ssp_pkg::IDX_CONT_CTRL, {sw, 7'h00});
        n0 = nlow;
        wr(ssp_pkg::IDX_CONTROL, {bank, sw, 2'b11, msb, 3'b001});
        if (sw)
        begin
            k = 0;
            do
            begin
                rg(ssp_pkg::IDX_CONT_CTRL, r);
                k++;
            end
            while (r[4:0] !== 5'h01 && k < 200);
            k = nlow;
            repeat (40) @(posedge clk_sys);
            rc(ssp_pkg::IDX_CONT_CTRL, 8'h81);
            chk(32'(nlow - k), 32'h0);
            wr(ssp_pkg::IDX_CONT_CTRL, 8'h00);
        end
        wait_end();
        rc(ssp_pkg::IDX_CONTROL, {bank, sw, 2'b00, msb, 3'b011});
        rc(ssp_pkg::IDX_CONT_CTRL, 8'(nb - 1));
        chk(32'(nlow - n0), 32'(nbits * (dv + 1)));
        chk(rx, tx_stream(by, nbits, msb));
        for (k = 0; k < 4; k++)
        begin
            e = by[8 * k +: 8];
            if (sw && k == 0)
                e = d;
            else if (sw && k < nb)
                e = sh_in(8'h00, pat >> (8 * (k - 1)), 8, msb);
            rc(ssp_pkg::IDX_RAM_BASE + {10'h000, bank, 5'(k)}, e);
        end
        e = sh_in(by[8 * (nb - 1) +: 8], pat >> (8 * (nb - 1)), nbits - 8 * (nb - 1), msb);
        rc(ssp_pkg::IDX_SHIFT, e);
        $display("cont %0d %0d done", sw, nbits);
    endtask
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // ==========================================================
    // main sequence and watchdog
    initial
    begin
        logic [31:0] r;
        logic e;
        void'($urandom(32'hDFE4));
        repeat (6) @(posedge clk_sys);
        reset <= 1'b0;
        clr <= 1'b0;
        for (int t = 0; t < 8; t++)
            if (t < 4 || t == 7)
                rc(ssp_pkg::IDX_CONTROL + 16'(t), 8'h00);
        wr(ssp_pkg::IDX_SHIFT, 8'h5A);
        rc(ssp_pkg::IDX_SHIFT, 8'h5A);
        for (int t = 0; t < 2; t++)
        begin
            apb(t[0], 16'hFE34, 8'hA5, r, e);
            chk({31'h0, e}, 32'h1);
        end
        $display("regs done");
        for (int t = 0; t < 4; t++)
            single(t[0], t[1]);
        setup(1'b1, 8'h04);
        kick(9'h001);
        repeat (20) @(posedge clk_sys);
        rc(ssp_pkg::IDX_CONTROL, 8'h04);
        wr(ssp_pkg::IDX_CONTROL, 8'h00);
        rc(ssp_pkg::IDX_CONTROL, 8'h00);
        $display("overrun done");
        for (int t = 0; t < 2; t++)
            cont(t[0]);
        end_of_test();
    end
    initial
    begin
        repeat (60000) @(posedge clk_sys);
        n_mismatch++;
        $display("watchdog t=%0t", $time);
        end_of_test();
    end
endmodule
`default_nettype wire
